// ==== src/pocp_pkg.sv ====
package pocp_pkg;
  // ----------------------------------------------------------------
  // Device register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_SCAN_CMD = 8'h01;
  localparam logic [7:0] REG_SC_LIMIT = 8'h0A;
  localparam logic [7:0] REG_DOC_LIMIT = 8'h0B;
  localparam logic [7:0] REG_SC_DELAY = 8'h0C;
  localparam logic [7:0] REG_CONFIG = 8'h0E;
  localparam logic [7:0] REG_COC_LIMIT = 8'h0F;
  localparam logic [7:0] REG_SWITCH = 8'h24;
  localparam logic [7:0] REG_SENSE_LO = 8'h52;
  localparam logic [7:0] REG_SENSE_HI = 8'h53;
  localparam logic [7:0] REG_STATUS = 8'h63;
  localparam logic [7:0] REG_MASK = 8'h83;
  // ----------------------------------------------------------------
  // Device fields and reset values
  // ----------------------------------------------------------------
  localparam int SCAN_GO_BIT = 0;
  localparam int CFG_AUTO_DOC_BIT = 7;
  localparam int CFG_AUTO_COC_BIT = 2;
  localparam int SW_DIS_BIT = 1;
  localparam int SW_CHG_BIT = 0;
  localparam int FLT_SC_BIT = 2;
  localparam int FLT_DOC_BIT = 3;
  localparam int FLT_COC_BIT = 4;
  localparam logic [7:0] FAULT_BITS = 8'h1C;
  localparam logic [7:0] SW_EN_BITS = 8'h03;
  localparam logic [7:0] SW_OFF_VALUE = 8'h00;
  localparam logic [7:0] RST_LIMIT = 8'hFF;
  localparam logic [7:0] RST_DELAY = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_SWITCH = 8'h00;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam int THR_SHIFT_DEF = 4;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_MHZ = 250;
  localparam int SC_TICK_NS = 1000;
  localparam int SC_TICK_CYCLES = (SC_TICK_NS * SYS_CLK_MHZ + 999) / 1000;
  // ----------------------------------------------------------------
  // Host register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [4:0] HR_CTRL = 5'h00;
  localparam logic [4:0] HR_STATUS = 5'h04;
  localparam logic [4:0] HR_MASK = 5'h08;
  localparam logic [4:0] HR_RSENSE = 5'h0C;
  localparam logic [4:0] HR_DOC_LIM = 5'h10;
  localparam logic [4:0] HR_COC_LIM = 5'h14;
  localparam logic [4:0] HR_SENSE = 5'h18;
  localparam logic [4:0] HR_DEV_WR = 5'h1C;
  localparam int HC_START_BIT = 0;
  localparam int HC_AUTO_BIT = 1;
  localparam int HS_DEV_DOC = 0;
  localparam int HS_DEV_COC = 1;
  localparam int HS_DEV_SC = 2;
  localparam int HS_RED_DOC = 3;
  localparam int HS_RED_COC = 4;
  localparam int HS_ADC_DOC = 5;
  localparam int HS_ADC_COC = 6;
  localparam int HS_DONE = 7;
  localparam logic [7:0] HS_FAULT_BITS = 8'h7F;
  localparam logic [7:0] RST_HCTRL = 8'h00;
  localparam logic [7:0] RST_HMASK = 8'hFF;
  localparam logic [15:0] RST_RSENSE = 16'h0001;
  localparam logic [15:0] RST_HLIM = 16'h7FFF;
endpackage

// ==== src/pocp_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface pocp_if;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic regWrite;
  logic regRead;
  logic [7:0] regRdata;
  logic regAck;
  logic regAlert;
  modport dev (
    input regAddr, regWdata, regWrite, regRead,
    output regRdata, regAck, regAlert
  );
  modport host (
    output regAddr, regWdata, regWrite, regRead,
    input regRdata, regAck, regAlert
  );
endinterface
`default_nettype wire

// ==== src/pocp_device.sv ====
// Behaviour
// - Scan flags discharge fault at or below limit
// - Discharge limit is unsigned negative magnitude
// - Discharge flag status bit 3, mask 3
// - Host reads flag by poll or alert
// - Host clears switch enables as reaction
// - Config bit 7 auto-off on discharge fault
// - Automatic isolation and alert without host
// - Host redundant check on sense result
// - Host converts own ADC voltage to current
// - Host redundant fault triggers reaction and alert
// - Host commands scan before checking flags
// - Scan flags charge fault at or above limit
// - Charge flag status bit 4, mask 4
// - Config bit 2 auto-off on charge fault
// - Host flags charge fault at or above limit
// - Short flag after programmed delay below limit
// - Short fault opens switches, stops scan, idles
// - Short alert gated by mask bit 2
`timescale 1ns/1ns
`default_nettype none
module pocp_device #(
  parameter int THR_SHIFT = pocp_pkg::THR_SHIFT_DEF,
  parameter int SC_TICK = pocp_pkg::SC_TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sysCe,
  pocp_if.dev link,
  input wire logic [15:0] senseVoltage,
  output logic chargeSwitch,
  output logic dischargeSwitch,
  output logic idleMode
);
  // ----------------------------------------------------------------
  // Limit scaling
  // ----------------------------------------------------------------
  function automatic logic signed [16:0] limitLevel(
    input logic [7:0] lim
  );
    logic [15:0] wide;
    wide = 16'(lim) << THR_SHIFT;
    limitLevel = $signed({1'b0, wide});
  endfunction

  logic [7:0] scLimitReg;
  logic [7:0] docLimitReg;
  logic [7:0] scDelayReg;
  logic [7:0] configReg;
  logic [7:0] cocLimitReg;
  logic [7:0] switchReg;
  logic [15:0] resultReg;
  logic [7:0] statusReg;
  logic [7:0] maskReg;
  logic scanPendReg;
  logic idleReg;
  logic alertReg;
  logic ackReg;
  logic [7:0] rdataReg;
  logic [15:0] tickCntReg;
  logic [7:0] scTicksReg;

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  logic devWr;
  logic devRd;
  logic wrScan;
  logic wrScLim;
  logic wrDocLim;
  logic wrScDly;
  logic wrConfig;
  logic wrCocLim;
  logic wrSwitch;
  logic wrStatus;
  logic wrMask;
  logic [7:0] rdMux;
  assign devWr = link.regWrite && !ackReg;
  assign devRd = link.regRead && !ackReg;
  assign wrScan = devWr && (link.regAddr == pocp_pkg::REG_SCAN_CMD);
  assign wrScLim = devWr && (link.regAddr == pocp_pkg::REG_SC_LIMIT);
  assign wrDocLim = devWr && (link.regAddr == pocp_pkg::REG_DOC_LIMIT);
  assign wrScDly = devWr && (link.regAddr == pocp_pkg::REG_SC_DELAY);
  assign wrConfig = devWr && (link.regAddr == pocp_pkg::REG_CONFIG);
  assign wrCocLim = devWr && (link.regAddr == pocp_pkg::REG_COC_LIMIT);
  assign wrSwitch = devWr && (link.regAddr == pocp_pkg::REG_SWITCH);
  assign wrStatus = devWr && (link.regAddr == pocp_pkg::REG_STATUS);
  assign wrMask = devWr && (link.regAddr == pocp_pkg::REG_MASK);
  assign rdMux =
    (link.regAddr == pocp_pkg::REG_SC_LIMIT) ? scLimitReg :
    (link.regAddr == pocp_pkg::REG_DOC_LIMIT) ? docLimitReg :
    (link.regAddr == pocp_pkg::REG_SC_DELAY) ? scDelayReg :
    (link.regAddr == pocp_pkg::REG_CONFIG) ? configReg :
    (link.regAddr == pocp_pkg::REG_COC_LIMIT) ? cocLimitReg :
    (link.regAddr == pocp_pkg::REG_SWITCH) ? switchReg :
    (link.regAddr == pocp_pkg::REG_SENSE_LO) ? resultReg[7:0] :
    (link.regAddr == pocp_pkg::REG_SENSE_HI) ? resultReg[15:8] :
    (link.regAddr == pocp_pkg::REG_STATUS) ? statusReg :
    (link.regAddr == pocp_pkg::REG_MASK) ? maskReg :
    8'h00;

  // ----------------------------------------------------------------
  // Fault detection
  // ----------------------------------------------------------------
  logic signed [16:0] sense17;
  logic docHit;
  logic cocHit;
  logic scOver;
  logic scanNow;
  logic docSet;
  logic cocSet;
  logic scSet;
  logic scTick;
  logic autoOff;
  assign sense17 = $signed({senseVoltage[15], senseVoltage});
  // Limit is a magnitude; compare against its negation
  assign docHit = (sense17 < 0) &&
    (sense17 <= -limitLevel(docLimitReg));
  assign cocHit = (sense17 > 0) &&
    (sense17 >= limitLevel(cocLimitReg));
  assign scOver = sense17 < -limitLevel(scLimitReg);
  // No scan while idling after a short
  assign scanNow = scanPendReg && !idleReg;
  assign docSet = scanNow && docHit;
  assign cocSet = scanNow && cocHit;
  assign scSet = scOver && (scTicksReg >= scDelayReg);
  assign scTick = tickCntReg == 16'(SC_TICK - 1);
  assign autoOff = scSet ||
    (docSet && configReg[pocp_pkg::CFG_AUTO_DOC_BIT]) ||
    (cocSet && configReg[pocp_pkg::CFG_AUTO_COC_BIT]);

  // ----------------------------------------------------------------
  // Flag, switch and alert next values
  // ----------------------------------------------------------------
  logic [7:0] fltSet;
  logic [7:0] fltClr;
  logic [7:0] statusNext;
  logic [7:0] maskNext;
  logic [7:0] switchWr;
  logic [7:0] switchNext;
  logic idleNext;
  logic alertNext;
  always_comb begin
    fltSet = 8'h00;
    fltSet[pocp_pkg::FLT_SC_BIT] = scSet;
    fltSet[pocp_pkg::FLT_DOC_BIT] = docSet;
    fltSet[pocp_pkg::FLT_COC_BIT] = cocSet;
  end
  assign fltClr = wrStatus ? (link.regWdata & pocp_pkg::FAULT_BITS) : 8'h00;
  // A new event outlives a clear in the same cycle
  assign statusNext = (statusReg & ~fltClr) | fltSet;
  assign maskNext = wrMask ? link.regWdata : maskReg;
  assign switchWr = wrSwitch ?
    (link.regWdata & pocp_pkg::SW_EN_BITS) : switchReg;
  // Automatic shutoff overrides any write
  assign switchNext = autoOff ?
    pocp_pkg::SW_OFF_VALUE : switchWr;
  assign idleNext = scSet ||
    (idleReg && statusNext[pocp_pkg::FLT_SC_BIT]);
  assign alertNext = |(statusNext & ~maskNext &
    pocp_pkg::FAULT_BITS);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scLimitReg <= pocp_pkg::RST_LIMIT;
      docLimitReg <= pocp_pkg::RST_LIMIT;
      scDelayReg <= pocp_pkg::RST_DELAY;
      configReg <= pocp_pkg::RST_CONFIG;
      cocLimitReg <= pocp_pkg::RST_LIMIT;
      maskReg <= pocp_pkg::RST_MASK;
    end else if (sysCe) begin
      if (wrScLim) begin
        scLimitReg <= link.regWdata;
      end
      if (wrDocLim) begin
        docLimitReg <= link.regWdata;
      end
      if (wrScDly) begin
        scDelayReg <= link.regWdata;
      end
      if (wrConfig) begin
        configReg <= link.regWdata;
      end
      if (wrCocLim) begin
        cocLimitReg <= link.regWdata;
      end
      maskReg <= maskNext;
    end
  end

  // ----------------------------------------------------------------
  // Scan, flags, switches and alert
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scanPendReg <= 1'b0;
      resultReg <= 16'h0000;
      statusReg <= 8'h00;
      switchReg <= pocp_pkg::RST_SWITCH;
      idleReg <= 1'b0;
      alertReg <= 1'b0;
    end else if (sysCe) begin
      scanPendReg <= wrScan && link.regWdata[pocp_pkg::SCAN_GO_BIT];
      if (scanNow) begin
        resultReg <= senseVoltage;
      end
      statusReg <= statusNext;
      switchReg <= switchNext;
      idleReg <= idleNext;
      alertReg <= alertNext;
    end
  end

  // ----------------------------------------------------------------
  // Short-circuit delay timer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCntReg <= 16'h0000;
      scTicksReg <= 8'h00;
    end else if (sysCe) begin
      if (!scOver) begin
        tickCntReg <= 16'h0000;
        scTicksReg <= 8'h00;
      end else if (scTick) begin
        tickCntReg <= 16'h0000;
        if (scTicksReg != 8'hFF) begin
          scTicksReg <= scTicksReg + 8'h01;
        end
      end else begin
        tickCntReg <= tickCntReg + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register port answer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ackReg <= 1'b0;
      rdataReg <= 8'h00;
    end else if (sysCe) begin
      ackReg <= (link.regWrite || link.regRead) && !ackReg;
      if (devRd) begin
        rdataReg <= rdMux;
      end
    end
  end

  assign link.regAck = ackReg;
  assign link.regRdata = rdataReg;
  assign link.regAlert = alertReg;
  assign chargeSwitch = switchReg[pocp_pkg::SW_CHG_BIT];
  assign dischargeSwitch = switchReg[pocp_pkg::SW_DIS_BIT];
  assign idleMode = idleReg;
endmodule
`default_nettype wire

// ==== src/pocp_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module pocp_host (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sysCe,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic [15:0] adcVoltage,
  input wire logic adcValid,
  output logic hostAlert,
  pocp_if.host link
);
  typedef enum logic [7:0] {
    H_IDLE = 8'b00000001,
    H_SCAN = 8'b00000010,
    H_STAT = 8'b00000100,
    H_LO = 8'b00001000,
    H_HI = 8'b00010000,
    H_EVAL = 8'b00100000,
    H_OFF = 8'b01000000,
    H_CFG = 8'b10000000
  } pocp_hstate_e;

  function automatic logic signed [33:0] scaled(
    input logic [15:0] lim,
    input logic [15:0] r
  );
    logic [31:0] p;
    p = lim * r;
    scaled = $signed({2'b00, p});
  endfunction

  pocp_hstate_e stateReg;
  pocp_hstate_e stateNext;
  logic [7:0] ctrlReg;
  logic [7:0] statusReg;
  logic [7:0] maskReg;
  logic [15:0] rsenseReg;
  logic [15:0] docLimReg;
  logic [15:0] cocLimReg;
  logic [7:0] devStatReg;
  logic [7:0] loReg;
  logic [7:0] hiReg;
  logic busRdReg;
  logic busWrReg;
  logic [7:0] busAddrReg;
  logic [7:0] busWdataReg;
  logic startPendReg;
  logic adcPendReg;
  logic alertPrevReg;
  logic avWaitReg;
  logic [31:0] avDataReg;
  logic irqReg;
  logic alertReg;
  logic cfgPendReg;
  logic [15:0] cfgReg;

  // ----------------------------------------------------------------
  // Avalon slave decode
  // ----------------------------------------------------------------
  logic avWr;
  logic [31:0] avMux;
  logic [7:0] hClr;
  logic cfgTrig;
  assign avWr = avs_write && !avWaitReg;
  assign avMux =
    (avs_address == pocp_pkg::HR_CTRL) ? {24'h00_0000, ctrlReg} :
    (avs_address == pocp_pkg::HR_STATUS) ? {24'h00_0000, statusReg} :
    (avs_address == pocp_pkg::HR_MASK) ? {24'h00_0000, maskReg} :
    (avs_address == pocp_pkg::HR_RSENSE) ? {16'h0000, rsenseReg} :
    (avs_address == pocp_pkg::HR_DOC_LIM) ? {16'h0000, docLimReg} :
    (avs_address == pocp_pkg::HR_COC_LIM) ? {16'h0000, cocLimReg} :
    (avs_address == pocp_pkg::HR_SENSE) ? {16'h0000, hiReg, loReg} :
    32'h0000_0000;
  assign hClr = (avWr && avs_address == pocp_pkg::HR_STATUS) ?
    avs_writedata[7:0] : 8'h00;
  // Software write of {device address, data} passed on to the device
  assign cfgTrig = avWr && avs_address == pocp_pkg::HR_DEV_WR;

  // ----------------------------------------------------------------
  // Fault evaluation
  // ----------------------------------------------------------------
  logic signed [33:0] docScaled;
  logic signed [33:0] cocScaled;
  logic signed [33:0] sense34;
  logic signed [33:0] adc34;
  logic redDoc;
  logic redCoc;
  logic adcDoc;
  logic adcCoc;
  logic devFault;
  logic anyFault;
  logic [7:0] hSet;
  logic startTrig;
  logic busReq;
  logic busAck;
  logic busActive;
  logic opWrite;
  logic [7:0] opAddr;
  // Compare V against limit*R instead of dividing V by R
  assign docScaled = scaled(docLimReg, rsenseReg);
  assign cocScaled = scaled(cocLimReg, rsenseReg);
  assign sense34 = 34'($signed({hiReg, loReg}));
  assign adc34 = 34'($signed(adcVoltage));
  assign redDoc = sense34 <= -docScaled;
  assign redCoc = sense34 >= cocScaled;
  assign adcDoc = adcValid && (-adc34 >= docScaled);
  assign adcCoc = adcValid && (adc34 >= cocScaled);
  assign devFault = |(devStatReg & pocp_pkg::FAULT_BITS);
  assign anyFault = devFault || redDoc || redCoc;
  always_comb begin
    hSet = 8'h00;
    if (stateReg == H_EVAL) begin
      hSet[pocp_pkg::HS_DEV_DOC] = devStatReg[pocp_pkg::FLT_DOC_BIT];
      hSet[pocp_pkg::HS_DEV_COC] = devStatReg[pocp_pkg::FLT_COC_BIT];
      hSet[pocp_pkg::HS_DEV_SC] = devStatReg[pocp_pkg::FLT_SC_BIT];
      hSet[pocp_pkg::HS_RED_DOC] = redDoc;
      hSet[pocp_pkg::HS_RED_COC] = redCoc;
      hSet[pocp_pkg::HS_DONE] = 1'b1;
    end
    hSet[pocp_pkg::HS_ADC_DOC] = adcDoc;
    hSet[pocp_pkg::HS_ADC_COC] = adcCoc;
  end
  assign startTrig =
    (avWr && avs_address == pocp_pkg::HR_CTRL &&
     avs_writedata[pocp_pkg::HC_START_BIT]) ||
    (ctrlReg[pocp_pkg::HC_AUTO_BIT] &&
     link.regAlert && !alertPrevReg);

  // ----------------------------------------------------------------
  // Device access sequencer
  // ----------------------------------------------------------------
  assign busReq = busRdReg || busWrReg;
  assign busAck = busReq && link.regAck;
  assign busActive = (stateReg != H_IDLE) && (stateReg != H_EVAL);
  assign opWrite = (stateReg == H_SCAN) || (stateReg == H_OFF) ||
    (stateReg == H_CFG);
  assign opAddr =
    (stateReg == H_SCAN) ? pocp_pkg::REG_SCAN_CMD :
    (stateReg == H_STAT) ? pocp_pkg::REG_STATUS :
    (stateReg == H_LO) ? pocp_pkg::REG_SENSE_LO :
    (stateReg == H_HI) ? pocp_pkg::REG_SENSE_HI :
    (stateReg == H_CFG) ? cfgReg[15:8] :
    pocp_pkg::REG_SWITCH;
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      H_IDLE: begin
        if (startPendReg) begin
          stateNext = H_SCAN;
        end else if (adcPendReg) begin
          stateNext = H_OFF;
        end else if (cfgPendReg) begin
          stateNext = H_CFG;
        end
      end
      H_SCAN: stateNext = busAck ? H_STAT : H_SCAN;
      H_STAT: stateNext = busAck ? H_LO : H_STAT;
      H_LO: stateNext = busAck ? H_HI : H_LO;
      H_HI: stateNext = busAck ? H_EVAL : H_HI;
      H_EVAL: stateNext = anyFault ? H_OFF : H_IDLE;
      H_OFF: stateNext = busAck ? H_IDLE : H_OFF;
      H_CFG: stateNext = busAck ? H_IDLE : H_CFG;
      default: stateNext = H_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= H_IDLE;
      busRdReg <= 1'b0;
      busWrReg <= 1'b0;
      busAddrReg <= 8'h00;
      busWdataReg <= 8'h00;
    end else if (sysCe) begin
      stateReg <= stateNext;
      if (busAck) begin
        busRdReg <= 1'b0;
        busWrReg <= 1'b0;
      end else if (busActive && !busReq) begin
        busRdReg <= !opWrite;
        busWrReg <= opWrite;
        busAddrReg <= opAddr;
        // Scan command, software device write data, or both switch enables cleared
        busWdataReg <= (stateReg == H_SCAN) ? 8'h01 :
          (stateReg == H_CFG) ? cfgReg[7:0] :
          pocp_pkg::SW_OFF_VALUE;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      devStatReg <= 8'h00;
      loReg <= 8'h00;
      hiReg <= 8'h00;
      startPendReg <= 1'b0;
      adcPendReg <= 1'b0;
      alertPrevReg <= 1'b0;
      cfgPendReg <= 1'b0;
      cfgReg <= 16'h0000;
    end else if (sysCe) begin
      if (busAck && stateReg == H_STAT) begin
        devStatReg <= link.regRdata;
      end
      if (busAck && stateReg == H_LO) begin
        loReg <= link.regRdata;
      end
      if (busAck && stateReg == H_HI) begin
        hiReg <= link.regRdata;
      end
      startPendReg <= startTrig ||
        (startPendReg && stateReg != H_IDLE);
      adcPendReg <= adcDoc || adcCoc || (adcPendReg &&
        !(stateReg == H_IDLE && !startPendReg));
      alertPrevReg <= link.regAlert;
      if (cfgTrig) begin
        cfgReg <= avs_writedata[15:0];
      end
      cfgPendReg <= cfgTrig || (cfgPendReg && stateReg != H_CFG);
    end
  end

  // ----------------------------------------------------------------
  // Software registers and interrupt
  // ----------------------------------------------------------------
  logic [7:0] statusNext;
  assign statusNext = (statusReg & ~hClr) | hSet;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlReg <= pocp_pkg::RST_HCTRL;
      statusReg <= 8'h00;
      maskReg <= pocp_pkg::RST_HMASK;
      rsenseReg <= pocp_pkg::RST_RSENSE;
      docLimReg <= pocp_pkg::RST_HLIM;
      cocLimReg <= pocp_pkg::RST_HLIM;
      avWaitReg <= 1'b1;
      avDataReg <= 32'h0000_0000;
      irqReg <= 1'b0;
      alertReg <= 1'b0;
    end else if (sysCe) begin
      avWaitReg <= !((avs_read || avs_write) && avWaitReg);
      if (avs_read && avWaitReg) begin
        avDataReg <= avMux;
      end
      if (avWr && avs_address == pocp_pkg::HR_CTRL) begin
        ctrlReg <= avs_writedata[7:0] & 8'h02;
      end
      if (avWr && avs_address == pocp_pkg::HR_MASK) begin
        maskReg <= avs_writedata[7:0];
      end
      if (avWr && avs_address == pocp_pkg::HR_RSENSE) begin
        rsenseReg <= avs_writedata[15:0];
      end
      if (avWr && avs_address == pocp_pkg::HR_DOC_LIM) begin
        docLimReg <= avs_writedata[15:0];
      end
      if (avWr && avs_address == pocp_pkg::HR_COC_LIM) begin
        cocLimReg <= avs_writedata[15:0];
      end
      statusReg <= statusNext;
      irqReg <= |(statusNext & ~maskReg);
      alertReg <= |(statusNext & pocp_pkg::HS_FAULT_BITS);
    end
  end

  assign avs_waitrequest = avWaitReg;
  assign avs_readdata = avDataReg;
  assign irq = irqReg;
  assign hostAlert = alertReg;
  assign link.regAddr = busAddrReg;
  assign link.regWdata = busWdataReg;
  assign link.regRead = busRdReg;
  assign link.regWrite = busWrReg;
endmodule
`default_nettype wire

// ==== tb/pocp_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module pocp_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic regAck,
  input wire logic regAlert
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] mask_reg;
  wire logic take = (regRead | regWrite) & ~regAck;
  wire logic maskWr = take & regWrite & (regAddr == pocp_pkg::REG_MASK);
  wire logic swWr = take & regWrite & (regAddr == pocp_pkg::REG_SWITCH);
  wire logic stRd = take & regRead & (regAddr == pocp_pkg::REG_STATUS);
  // Shadow of the device alert mask
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) mask_reg <= pocp_pkg::RST_MASK;
    else if (maskWr) mask_reg <= regWdata;
  end
  sequence s_take;
    take;
  endsequence
  sequence s_stat_read;
    stRd;
  endsequence
  property p_ack; s_take |=> regAck; endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_ack_pulse; regAck |=> !regAck; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_rw_excl; !(regRead && regWrite); endproperty
  a_rw_excl: assert property (p_rw_excl) else $error("read and write");
  property p_hold; s_take |=> $stable({regAddr, regWdata, regRead}); endproperty
  a_hold: assert property (p_hold) else $error("request changed");
  property p_drop; regAck |=> !regRead && !regWrite; endproperty
  a_drop: assert property (p_drop) else $error("request not dropped");
  property p_alert_masked;
    (mask_reg & pocp_pkg::FAULT_BITS) == pocp_pkg::FAULT_BITS |-> !regAlert;
  endproperty
  a_alert_masked: assert property (p_alert_masked)
    else $error("alert while masked");
  property p_stat_rsvd;
    s_stat_read |=> (regRdata & ~pocp_pkg::FAULT_BITS) == 8'h00;
  endproperty
  a_stat_rsvd: assert property (p_stat_rsvd)
    else $error("status spare bits set");
  property p_sw_off; swWr |-> regWdata == pocp_pkg::SW_OFF_VALUE; endproperty
  a_sw_off: assert property (p_sw_off) else $error("switch not off");
  property p_rdata; !(take && regRead) |=> $stable(regRdata); endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved");
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic sys_clk = 1'b0, rst_n = 1'b0;
  logic avs_read = 1'b0, avs_write = 1'b0, adcValid = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, irq, hostAlert, chargeSwitch, dischargeSwitch, idleMode;
  logic [15:0] senseVoltage = 16'h0000, adcVoltage = 16'h0000;
  int n_errors = 0, n_tests = 0, seed = 32'h3760;
  pocp_if pocp_if_i ();
  pocp_device #(.SC_TICK(2)) pocp_device_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .sysCe(1'b1), .link(pocp_if_i.dev), .senseVoltage(senseVoltage),
    .chargeSwitch(chargeSwitch), .dischargeSwitch(dischargeSwitch),
    .idleMode(idleMode));
  pocp_host pocp_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .sysCe(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .adcVoltage(adcVoltage),
    .adcValid(adcValid), .hostAlert(hostAlert), .link(pocp_if_i.host));
  pocp_asserts pocp_asserts_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .regAddr(pocp_if_i.regAddr), .regWdata(pocp_if_i.regWdata),
    .regWrite(pocp_if_i.regWrite), .regRead(pocp_if_i.regRead),
    .regRdata(pocp_if_i.regRdata), .regAck(pocp_if_i.regAck),
    .regAlert(pocp_if_i.regAlert));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic poll(output logic [31:0] q);
    do begin
      bus(1'b0, pocp_pkg::HR_STATUS, 32'h0000_0000, q);
    end while (q[pocp_pkg::HS_DONE] !== 1'b1);
  endtask
  task automatic devWrite(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, pocp_pkg::HR_DEV_WR, {16'h0000, a, d}, q);
    // Leaves the host time to pass the write on
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic summarize();
    $display("errors=%0d tests=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    #200000;
    n_errors++;
    summarize();
  end
  initial begin
    logic [31:0] q;
    int v, sv, dev, st;
    int vals[9];
    vals = '{0, -199, 399, -200, 400, -4079, 4079, -4080, 4080};
    sv = 0;
    dev = 0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(1'b0, 5'h1C, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    bus(1'b0, pocp_pkg::HR_DOC_LIM, 32'h0000_0000, q);
    chk(q, {16'h0000, pocp_pkg::RST_HLIM});
    bus(1'b1, pocp_pkg::HR_MASK, 32'h0000_0080, q);
    bus(1'b1, pocp_pkg::HR_RSENSE, 32'h0000_0002, q);
    bus(1'b1, pocp_pkg::HR_DOC_LIM, 32'h0000_0064, q);
    bus(1'b1, pocp_pkg::HR_COC_LIM, 32'h0000_00C8, q);
    for (int i = 0; i < 16; i++) begin
      v = (i < 9) ? vals[i] : $random(seed) % 4000;
      if (i == 15) v = -4081;
      senseVoltage <= v[15:0];
      adcVoltage <= v[15:0];
      // Short circuit idles the device, so the scan result stays stale
      if (v < -4080) dev |= 4;
      else sv = v;
      if (v >= 4080) dev |= 2;
      if (v == -4080) dev |= 1;
      bus(1'b1, pocp_pkg::HR_CTRL, 32'h0000_0001, q);
      poll(q);
      @(posedge sys_clk);
      adcValid <= 1'b1;
      @(posedge sys_clk);
      adcValid <= 1'b0;
      st = dev | (sv <= -200 ? 8 : 0) | (sv >= 400 ? 16 : 0) | 128;
      st |= (v <= -200 ? 32 : 0) | (v >= 400 ? 64 : 0);
      bus(1'b0, pocp_pkg::HR_SENSE, 32'h0000_0000, q);
      chk(q, {16'h0000, sv[15:0]});
      bus(1'b0, pocp_pkg::HR_STATUS, 32'h0000_0000, q);
      chk(q, st);
      chk(32'(irq), 32'((st & 127) != 0));
      chk(32'(hostAlert), 32'((st & 127) != 0));
      bus(1'b1, pocp_pkg::HR_STATUS, 32'h0000_00FF, q);
    end
    chk(32'(idleMode), 32'h0000_0001);
    chk(32'({chargeSwitch, dischargeSwitch}), 32'h0000_0000);
    // Delayed short circuit, unmasked, wakes the host through the alert
    senseVoltage <= 16'h0000;
    devWrite(pocp_pkg::REG_STATUS, 8'h1C);
    devWrite(pocp_pkg::REG_SC_DELAY, 8'h02);
    devWrite(pocp_pkg::REG_MASK, 8'h00);
    bus(1'b1, pocp_pkg::HR_CTRL, 32'h0000_0002, q);
    senseVoltage <= 16'hF00F;
    poll(q);
    chk(q, 132 | (sv <= -200 ? 8 : 0) | (sv >= 400 ? 16 : 0));
    chk(32'(pocp_if_i.regAlert), 32'h0000_0001);
    summarize();
  end
endmodule
`default_nettype wire
